// >>> include/sled_map.vh
// Purpose: Offsets, field positions and reset values of the event detect block.
// Assumes: Wishbone classic slave, 32-bit data, byte addresses.
// Notes: Included by the event detect design file only.
`ifndef SLED_MAP_VH
`define SLED_MAP_VH
`define SLED_ADR_STATUS      8'h00
`define SLED_ADR_INT_EN      8'h04
`define SLED_ADR_PW_EN       8'h08
`define SLED_ADR_ERR_EN      8'h0C
`define SLED_ADR_TLM_CTL     8'h10
`define SLED_ADR_MECS_STAT   8'h14
`define SLED_ADR_BASE_ID     8'h18
`define SLED_ADR_RTR_EN      8'h1C
`define SLED_ADR_RTR0        8'h20
`define SLED_ADR_RTR_LAST    8'h5C
`define SLED_ADR_PW_STATUS   8'h60
`define SLED_NUM_RTR         16
// Event status bit positions.
`define SLED_BIT_COR         0
`define SLED_BIT_UNCOR       1
`define SLED_BIT_LOCAL_ERR   2
`define SLED_BIT_FTYPE       3
`define SLED_BIT_ROUTE       4
`define SLED_BIT_MECS        5
`define SLED_NUM_EV          6
// Error enable bit positions.
`define SLED_EN_ILL_ID       0
`define SLED_EN_UNSUP_TYPE   1
`define SLED_EN_FTYPE_RPT    2
// TLM control bit positions.
`define SLED_CTL_TGT_DIS     0
`define SLED_CTL_MTC_DIS     1
`define SLED_CTL_FILT_CFG    2
`define SLED_CTL_MECS_CMD    3
// Packet field codes.
`define SLED_FTYPE_MAINT     4'h8
`define SLED_TT_ILL_LO       2'h2
`define SLED_TT_ILL_HI       2'h3
`define SLED_TTYPE_RD        4'h0
`define SLED_TTYPE_WR        4'h1
`define SLED_TTYPE_PW        4'h4
`define SLED_TTYPE_UNS_LO    4'h5
`define SLED_TTYPE_UNS_HI    4'hF
`define SLED_MAINT_LEN       8'h08
`define SLED_SIZE_OK         4'hB
`define SLED_RST_EN          32'h00000000
`endif

// >>> rtl/sled_route_match.v
// Purpose: Destination-ID match against routing registers and base ID.
// Assumes: Routing registers hold a 16-bit ID and a valid bit each.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sled_route_match
(
   input  wire [15:0]  dest_id_i,
   input  wire [15:0]  base_id_i,
   input  wire [255:0] rtr_id_i,
   input  wire [15:0]  rtr_valid_i,
   output reg          hit_o
);
   integer k;
   always @*
   begin
      hit_o = (dest_id_i == base_id_i);
      for (k = 0; k < 16; k = k + 1)
      begin
         if (rtr_valid_i[k] && (rtr_id_i[k*16 +: 16] == dest_id_i))
         begin
            hit_o = 1'b1;
         end
      end
   end
endmodule // sled_route_match
`default_nettype wire

// >>> rtl/sled_event_detect.v
// Purpose: Local logical/transport event detection and reporting.
// Assumes: Packet header fields arrive as one-cycle strobed words.
// Notes: Status bits are write-one-to-clear; a set wins over a clear.
`timescale 1ns/1ps
`default_nettype none
`include "sled_map.vh"
module sled_event_detect
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg         wb_ack_o,
   input  wire        pkt_valid_i,
   input  wire [1:0]  pkt_tt_i,
   input  wire [3:0]  pkt_ftype_i,
   input  wire [3:0]  pkt_ttype_i,
   input  wire [3:0]  pkt_size_i,
   input  wire [7:0]  pkt_len_i,
   input  wire [15:0] pkt_dest_id_i,
   input  wire        pkt_ftype_drop_i,
   input  wire        maint_bus_timeout_i,
   input  wire        maint_addr_error_i,
   input  wire        ecc_present_i,
   input  wire        ingress_correctable_corruption_i,
   input  wire        ingress_uncorrectable_corruption_i,
   input  wire        mecs_valid_i,
   input  wire [7:0]  mecs_cmd_i,
   output reg         maint_err_resp_o,
   output reg         pkt_discard_o,
   output wire        irq_o,
   output wire        port_write_req_o
);
   reg  [5:0]   int_status;
   reg  [5:0]   pw_status;
   reg  [5:0]   int_en;
   reg  [5:0]   pw_en;
   reg  [2:0]   err_en;
   reg  [3:0]   tlm_ctl;
   reg          port_mecs_evt;
   reg  [7:0]   port_mecs_cmd;
   reg  [15:0]  base_id;
   reg  [15:0]  rtr_valid;
   reg  [255:0] rtr_id;
   reg  [5:0]   next_int_set;
   reg  [5:0]   next_pw_set;
   wire         route_hit;
   wire         wb_req;
   wire         wb_wr;
   wire         is_maint;
   wire         maint_rw;
   wire         ill_decode;
   wire         tgt_check;
   wire         route_miss;
   wire         mecs_clr;
   integer      i;

   function [15:0] sled_merge;
      input [15:0] old_v;
      input [15:0] new_v;
      input [1:0]  sel;
      integer b;
      begin
         for (b = 0; b < 2; b = b + 1)
         begin
            sled_merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
         end
      end
   endfunction

   function sled_rtr_sel;
      input [7:0] adr;
      input [3:0] idx;
      begin
         sled_rtr_sel = (adr == (`SLED_ADR_RTR0 + {2'h0, idx, 2'h0}));
      end
   endfunction

   sled_route_match u_match
   (
      .dest_id_i   (pkt_dest_id_i),
      .base_id_i   (base_id),
      .rtr_id_i    (rtr_id),
      .rtr_valid_i (rtr_valid),
      .hit_o       (route_hit)
   );

   assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr    = wb_req && wb_we_i;
   assign is_maint = (pkt_ftype_i == `SLED_FTYPE_MAINT);
   assign maint_rw = is_maint && ((pkt_ttype_i == `SLED_TTYPE_RD) ||
                                  (pkt_ttype_i == `SLED_TTYPE_WR));
   assign ill_decode = pkt_valid_i && maint_rw &&
                       ((pkt_size_i > `SLED_SIZE_OK) ||
                        ((pkt_ttype_i == `SLED_TTYPE_WR) &&
                         (pkt_len_i != `SLED_MAINT_LEN)) ||
                        maint_bus_timeout_i || maint_addr_error_i);
   assign tgt_check  = !tlm_ctl[`SLED_CTL_TGT_DIS] && !tlm_ctl[`SLED_CTL_MTC_DIS];
   assign route_miss = pkt_valid_i && !ill_decode && tgt_check && !route_hit;
   assign mecs_clr   = wb_wr && wb_sel_i[0] && (wb_adr_i == `SLED_ADR_MECS_STAT);

   always @*
   begin
      next_int_set = 6'h00;
      next_pw_set  = 6'h00;
      if (ecc_present_i && ingress_correctable_corruption_i)
      begin
         next_int_set[`SLED_BIT_COR] = 1'b1;
         next_pw_set[`SLED_BIT_COR]  = 1'b1;
      end
      if (ecc_present_i && ingress_uncorrectable_corruption_i)
      begin
         next_int_set[`SLED_BIT_UNCOR] = 1'b1;
         next_pw_set[`SLED_BIT_UNCOR]  = 1'b1;
      end
      if (pkt_valid_i && !ill_decode)
      begin
         if (err_en[`SLED_EN_ILL_ID] &&
             ((pkt_tt_i == `SLED_TT_ILL_LO) || (pkt_tt_i == `SLED_TT_ILL_HI) ||
              route_miss))
         begin
            next_int_set[`SLED_BIT_LOCAL_ERR] = 1'b1;
            next_pw_set[`SLED_BIT_LOCAL_ERR]  = 1'b1;
         end
         if (err_en[`SLED_EN_UNSUP_TYPE] && is_maint &&
             (pkt_ttype_i >= `SLED_TTYPE_UNS_LO) &&
             (pkt_ttype_i <= `SLED_TTYPE_UNS_HI))
         begin
            next_int_set[`SLED_BIT_LOCAL_ERR] = 1'b1;
            next_pw_set[`SLED_BIT_LOCAL_ERR]  = 1'b1;
         end
         if (tlm_ctl[`SLED_CTL_FILT_CFG] && pkt_ftype_drop_i &&
             err_en[`SLED_EN_FTYPE_RPT])
         begin
            next_int_set[`SLED_BIT_FTYPE] = 1'b1;
            next_pw_set[`SLED_BIT_FTYPE]  = 1'b1;
         end
         if (route_miss)
         begin
            next_int_set[`SLED_BIT_ROUTE] = 1'b1;
            next_pw_set[`SLED_BIT_ROUTE]  = 1'b1;
         end
      end
      if (mecs_valid_i && tlm_ctl[`SLED_CTL_MECS_CMD])
      begin
         next_int_set[`SLED_BIT_MECS] = 1'b1;
      end
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         int_status       <= 6'h00;
         pw_status        <= 6'h00;
         int_en           <= 6'h00;
         pw_en            <= 6'h00;
         err_en           <= 3'h0;
         tlm_ctl          <= 4'h0;
         port_mecs_evt    <= 1'b0;
         port_mecs_cmd    <= 8'h00;
         base_id          <= 16'h0000;
         rtr_valid        <= 16'h0000;
         rtr_id           <= 256'h0;
         wb_ack_o         <= 1'b0;
         wb_dat_o         <= 32'h00000000;
         maint_err_resp_o <= 1'b0;
         pkt_discard_o    <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         maint_err_resp_o <= ill_decode;
         pkt_discard_o    <= route_miss ||
                             (pkt_valid_i && !ill_decode && pkt_ftype_drop_i &&
                              tlm_ctl[`SLED_CTL_FILT_CFG]);
         if (wb_wr && wb_sel_i[0] && (wb_adr_i == `SLED_ADR_STATUS))
         begin
            int_status <= (int_status & ~wb_dat_i[5:0]) | next_int_set;
         end
         else
         begin
            int_status <= int_status | next_int_set;
         end
         if (wb_wr && wb_sel_i[0] && (wb_adr_i == `SLED_ADR_PW_STATUS))
         begin
            pw_status <= (pw_status & ~wb_dat_i[5:0]) | next_pw_set;
         end
         else
         begin
            pw_status <= pw_status | next_pw_set;
         end
         port_mecs_evt <= (port_mecs_evt && !(mecs_clr && wb_dat_i[8])) || mecs_valid_i;
         if (mecs_clr)
         begin
            port_mecs_cmd <= (port_mecs_cmd & ~wb_dat_i[7:0]) |
                             (mecs_valid_i ? mecs_cmd_i : 8'h00);
         end
         else if (mecs_valid_i)
         begin
            port_mecs_cmd <= port_mecs_cmd | mecs_cmd_i;
         end
         if (wb_wr)
         begin
            case (wb_adr_i)
               `SLED_ADR_INT_EN:
               begin
                  if (wb_sel_i[0])
                  begin
                     int_en <= wb_dat_i[5:0];
                  end
               end
               `SLED_ADR_PW_EN:
               begin
                  if (wb_sel_i[0])
                  begin
                     pw_en <= {1'b0, wb_dat_i[4:0]};
                  end
               end
               `SLED_ADR_ERR_EN:
               begin
                  if (wb_sel_i[0])
                  begin
                     err_en <= wb_dat_i[2:0];
                  end
               end
               `SLED_ADR_TLM_CTL:
               begin
                  if (wb_sel_i[0])
                  begin
                     tlm_ctl <= wb_dat_i[3:0];
                  end
               end
               `SLED_ADR_BASE_ID:
               begin
                  base_id <= sled_merge(base_id, wb_dat_i[15:0], wb_sel_i[1:0]);
               end
               `SLED_ADR_RTR_EN:
               begin
                  rtr_valid <= sled_merge(rtr_valid, wb_dat_i[15:0], wb_sel_i[1:0]);
               end
               default:
               begin
                  for (i = 0; i < `SLED_NUM_RTR; i = i + 1)
                  begin
                     if (sled_rtr_sel(wb_adr_i, i[3:0]))
                     begin
                        rtr_id[i*16 +: 16] <= sled_merge(rtr_id[i*16 +: 16], wb_dat_i[15:0],
                                                         wb_sel_i[1:0]);
                     end
                  end
               end
            endcase
         end
         if (wb_req && !wb_we_i)
         begin
            case (wb_adr_i)
               `SLED_ADR_STATUS:     wb_dat_o <= {26'h0, int_status};
               `SLED_ADR_INT_EN:     wb_dat_o <= {26'h0, int_en};
               `SLED_ADR_PW_EN:      wb_dat_o <= {26'h0, pw_en};
               `SLED_ADR_ERR_EN:     wb_dat_o <= {29'h0, err_en};
               `SLED_ADR_TLM_CTL:    wb_dat_o <= {28'h0, tlm_ctl};
               `SLED_ADR_MECS_STAT:  wb_dat_o <= {23'h0, port_mecs_evt, port_mecs_cmd};
               `SLED_ADR_BASE_ID:    wb_dat_o <= {16'h0, base_id};
               `SLED_ADR_RTR_EN:     wb_dat_o <= {16'h0, rtr_valid};
               `SLED_ADR_PW_STATUS:  wb_dat_o <= {26'h0, pw_status};
               default:
               begin
                  wb_dat_o <= 32'h00000000;
                  for (i = 0; i < `SLED_NUM_RTR; i = i + 1)
                  begin
                     if (sled_rtr_sel(wb_adr_i, i[3:0]))
                     begin
                        wb_dat_o <= {16'h0, rtr_id[i*16 +: 16]};
                     end
                  end
               end
            endcase
         end
      end
   end

   assign irq_o            = |(int_status & int_en);
   assign port_write_req_o = |(pw_status[4:0] & pw_en[4:0]);
endmodule // sled_event_detect
`default_nettype wire

// >>> test/sled_event_monitor.sv
// Purpose: Port checks of the event detect block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the design below.
`timescale 1ns/1ps
`default_nettype none
module sled_event_monitor
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_we_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       pkt_valid_i,
   input wire logic [3:0] pkt_ftype_i,
   input wire logic [3:0] pkt_ttype_i,
   input wire logic [3:0] pkt_size_i,
   input wire logic [7:0] pkt_len_i,
   input wire logic       maint_bus_timeout_i,
   input wire logic       maint_addr_error_i,
   input wire logic       maint_err_resp_o,
   input wire logic       pkt_discard_o,
   input wire logic       irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire maint_pkt = pkt_valid_i && pkt_ftype_i == 4'h8;
   wire maint_rw  = maint_pkt && pkt_ttype_i <= 4'h1;
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_bus_ack_once: assert property (s_take |=> s_ack)
      else $error("Bus ack missing or too long.");
   a_bad_size: assert property (maint_rw && pkt_size_i > 4'hB |=> maint_err_resp_o)
      else $error("Bad size gave no error response.");
   a_bad_len: assert property (maint_pkt && pkt_ttype_i == 4'h1 && pkt_len_i != 8'h08
      |=> maint_err_resp_o) else $error("Bad length gave no error response.");
   a_bus_fault: assert property (maint_rw && (maint_bus_timeout_i || maint_addr_error_i)
      |=> maint_err_resp_o) else $error("Fault gave no error response.");
   a_pw_exempt: assert property (maint_pkt && pkt_ttype_i == 4'h4 && !maint_bus_timeout_i
      && !maint_addr_error_i |=> !maint_err_resp_o) else $error("Port-write refused.");
   a_err_quiet: assert property (maint_err_resp_o |-> $past(pkt_valid_i) && !pkt_discard_o)
      else $error("Error response without cause or with discard.");
   a_discard_cause: assert property (pkt_discard_o |-> $past(pkt_valid_i))
      else $error("Discard without packet.");
   a_irq_sticky: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
      else $error("Interrupt dropped without a write.");
endmodule // sled_event_monitor
bind sled_event_detect sled_event_monitor sled_event_monitor_i
(
   .clk_i, .rst_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pkt_valid_i, .pkt_ftype_i,
   .pkt_ttype_i, .pkt_size_i, .pkt_len_i, .maint_bus_timeout_i, .maint_addr_error_i,
   .maint_err_resp_o, .pkt_discard_o, .irq_o
);
`default_nettype wire

// >>> test/sled_link_partner.sv
// Purpose: Link partner sending request headers and event symbols.
// Assumes: A header lasts one clock.
// Notes: Idle lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module sled_link_partner
(
   input  wire logic        clk_i,
   output var  logic        pkt_valid_o,
   output wire logic [1:0]  pkt_tt_o,
   output wire logic [3:0]  pkt_ftype_o,
   output wire logic [3:0]  pkt_ttype_o,
   output wire logic [3:0]  pkt_size_o,
   output wire logic [7:0]  pkt_len_o,
   output wire logic [15:0] pkt_dest_id_o,
   output var  logic        mecs_valid_o,
   output var  logic [7:0]  mecs_cmd_o
);
   logic [37:0] hdr;
   assign {pkt_tt_o, pkt_ftype_o, pkt_ttype_o, pkt_size_o, pkt_len_o, pkt_dest_id_o} = hdr;
   initial
   begin
      hdr = 38'h0;
      pkt_valid_o = 1'b0;
      mecs_valid_o = 1'b0;
      mecs_cmd_o = 8'h00;
   end
   task automatic send(input logic [37:0] h);
      @(posedge clk_i);
      hdr <= h;
      pkt_valid_o <= 1'b1;
      @(posedge clk_i);
      hdr <= ~h;
      pkt_valid_o <= 1'b0;
   endtask
   task automatic mecs(input logic [7:0] c);
      @(posedge clk_i);
      mecs_cmd_o <= c;
      mecs_valid_o <= 1'b1;
      @(posedge clk_i);
      mecs_cmd_o <= ~c;
      mecs_valid_o <= 1'b0;
      #1;
   endtask
endmodule // sled_link_partner
`default_nettype wire

// >>> test/sled_tb.sv
// Purpose: Self-checking bench of the event detect block.
// Assumes: Classic Wishbone master, 4 ns clock.
// Notes: Packets and symbols come from the partner model.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_i, rst_i, we, cyc, stb, ecc, cor, unc, drop, tmo, aerr;
   logic [3:0]  sel;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat;
   wire         ack, err_rsp, disc, irq, pwr, pv, mv;
   wire  [31:0] dat_o;
   wire  [1:0]  tt;
   wire  [3:0]  ft, ty, sz;
   wire  [7:0]  len, mc;
   wire  [15:0] dst;
   int          num_errors = 0;
   int          check_count = 0;
   sled_event_detect sled_event_detect_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
      .pkt_valid_i(pv), .pkt_tt_i(tt), .pkt_ftype_i(ft), .pkt_ttype_i(ty), .pkt_size_i(sz),
      .pkt_len_i(len), .pkt_dest_id_i(dst), .pkt_ftype_drop_i(drop),
      .maint_bus_timeout_i(tmo), .maint_addr_error_i(aerr), .ecc_present_i(ecc),
      .ingress_correctable_corruption_i(cor), .ingress_uncorrectable_corruption_i(unc),
      .mecs_valid_i(mv), .mecs_cmd_i(mc), .maint_err_resp_o(err_rsp),
      .pkt_discard_o(disc), .irq_o(irq), .port_write_req_o(pwr)
   );
   sled_link_partner sled_link_partner_i
   (
      .clk_i(clk_i), .pkt_valid_o(pv), .pkt_tt_o(tt), .pkt_ftype_o(ft), .pkt_ttype_o(ty),
      .pkt_size_o(sz), .pkt_len_o(len), .pkt_dest_id_o(dst), .mecs_valid_o(mv),
      .mecs_cmd_o(mc)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic pkt(input logic [37:0] h, input logic [2:0] s);
      fork
         sled_link_partner_i.send(h);
         begin
            @(posedge clk_i);
            {drop, tmo, aerr} <= s;
            @(posedge clk_i);
            {drop, tmo, aerr} <= 3'h0;
         end
      join
      #1;
   endtask
   task automatic pulse(input logic u);
      @(posedge clk_i);
      if (u)
         unc <= 1'b1;
      else
         cor <= 1'b1;
      @(posedge clk_i);
      unc <= 1'b0;
      cor <= 1'b0;
      #1;
   endtask
   task automatic t_decode();
      bus(1'b1, 8'h0C, 32'h7);
      pkt({2'h2, 4'h8, 4'h0, 4'hC, 8'h08, 16'h0}, 3'h0);
      chk(err_rsp, 1);
      pkt({2'h2, 4'h8, 4'h1, 4'h2, 8'h04, 16'h0}, 3'h0);
      chk(err_rsp, 1);
      pkt({2'h0, 4'h8, 4'h0, 4'h2, 8'h08, 16'h0}, 3'h2);
      chk(err_rsp, 1);
      pkt({2'h0, 4'h8, 4'h1, 4'h2, 8'h08, 16'h0}, 3'h1);
      chk(err_rsp, 1);
      pkt({2'h0, 4'h8, 4'h4, 4'hF, 8'h08, 16'h0}, 3'h0);
      chk(err_rsp, 0);
      rdc(8'h00, 32'h0);
      bus(1'b1, 8'h80, 32'hFFFFFFFF);
      rdc(8'h80, 32'h0);
      $display("decode test done");
   endtask
   task automatic t_ecc();
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b1, 8'h08, 32'h2);
      pulse(1'b0);
      chk(irq, 0);
      @(posedge clk_i);
      ecc <= 1'b1;
      pulse(1'b0);
      chk({irq, pwr}, 2);
      pulse(1'b1);
      chk(pwr, 1);
      rdc(8'h00, 32'h3);
      rdc(8'h60, 32'h3);
      chk(irq, 1);
      bus(1'b1, 8'h00, 32'h3);
      chk(irq, 0);
      bus(1'b1, 8'h60, 32'h3);
      chk(pwr, 0);
      $display("ecc test done");
   endtask
   task automatic lc(input logic [3:0] c, input logic [2:0] e, input logic [37:0] h,
                     input logic [2:0] s, input logic [31:0] st, input logic dc);
      bus(1'b1, 8'h10, {28'h0, c});
      bus(1'b1, 8'h0C, {29'h0, e});
      pkt(h, s);
      chk(disc, dc);
      chk(irq, |st);
      rdc(8'h00, st);
      bus(1'b1, 8'h00, 32'h3F);
   endtask
   task automatic t_logic();
      bus(1'b1, 8'h04, 32'h1C);
      lc(4'h0, 3'h7, {2'h2, 4'h2, 4'h0, 4'h0, 8'h00, 16'h0}, 3'h0, 32'h04, 0);
      lc(4'h0, 3'h6, {2'h3, 4'h2, 4'h0, 4'h0, 8'h00, 16'h0}, 3'h0, 32'h00, 0);
      lc(4'h0, 3'h7, {2'h0, 4'h8, 4'h5, 4'h0, 8'h00, 16'h0}, 3'h0, 32'h04, 0);
      lc(4'h0, 3'h7, {2'h0, 4'h8, 4'hF, 4'h0, 8'h00, 16'h0}, 3'h0, 32'h04, 0);
      lc(4'h0, 3'h5, {2'h0, 4'h8, 4'h7, 4'h0, 8'h00, 16'h0}, 3'h0, 32'h00, 0);
      lc(4'h4, 3'h7, {2'h0, 4'h2, 4'h0, 4'h0, 8'h00, 16'h0}, 3'h4, 32'h08, 1);
      lc(4'h0, 3'h7, {2'h0, 4'h2, 4'h0, 4'h0, 8'h00, 16'h22}, 3'h0, 32'h14, 1);
      lc(4'h0, 3'h0, {2'h0, 4'h2, 4'h0, 4'h0, 8'h00, 16'h22}, 3'h0, 32'h10, 1);
      lc(4'h1, 3'h7, {2'h0, 4'h2, 4'h0, 4'h0, 8'h00, 16'h22}, 3'h0, 32'h00, 0);
      lc(4'h2, 3'h7, {2'h0, 4'h2, 4'h0, 4'h0, 8'h00, 16'h22}, 3'h0, 32'h00, 0);
      bus(1'b1, 8'h5C, 32'h22);
      bus(1'b1, 8'h1C, 32'h8000);
      lc(4'h0, 3'h7, {2'h0, 4'h2, 4'h0, 4'h0, 8'h00, 16'h22}, 3'h0, 32'h00, 0);
      $display("logical test done");
   endtask
   task automatic t_mecs();
      bus(1'b1, 8'h04, 32'h20);
      bus(1'b1, 8'h10, 32'h0);
      sled_link_partner_i.mecs(8'h05);
      chk(irq, 0);
      rdc(8'h14, 32'h105);
      rdc(8'h00, 32'h0);
      bus(1'b1, 8'h14, 32'h1FF);
      bus(1'b1, 8'h10, 32'h8);
      sled_link_partner_i.mecs(8'h81);
      chk(irq, 1);
      rdc(8'h14, 32'h181);
      $display("symbol test done");
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial
   begin
      {rst_i, we, cyc, stb, ecc, cor, unc, drop, tmo, aerr} = 10'h200;
      sel = 4'hF;
      adr = 8'h00;
      wdat = 32'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_decode();
      t_ecc();
      t_logic();
      t_mecs();
      print_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      print_verdict();
   end
endmodule // tb
`default_nettype wire
